// ### include/pwc_pkg.sv
// Constants, field layout and divide table of the periodic wakeup counter
package pwc_pkg;

  localparam int PWC_DATA_W = 8;
  localparam int PWC_PS_W = 4;
  localparam int PWC_CLKS_W = 2;
  localparam int PWC_DIV_W = 18;

  // Control/status field positions
  localparam int PWC_FLAG_BIT = 7;
  localparam int PWC_CLKS_MSB = 6;
  localparam int PWC_CLKS_LSB = 5;
  localparam int PWC_IE_BIT = 4;
  localparam int PWC_PS_MSB = 3;
  localparam int PWC_PS_LSB = 0;

  // Values after reset
  localparam logic [7:0] PWC_COUNT_RST = 8'h00;
  localparam logic [7:0] PWC_MOD_RST = 8'h00;
  localparam logic [1:0] PWC_CLKS_RST = 2'h0;
  localparam logic [3:0] PWC_PS_OFF = 4'h0;
  localparam logic [17:0] PWC_DIV_RST = 18'h00000;

  // Clock source codes; 2'h2 and 2'h3 both pick the internal clock
  localparam logic [1:0] PWC_SRC_LPO = 2'h0;
  localparam logic [1:0] PWC_SRC_EXT = 2'h1;

  // Source edges per prescaler output event; zero means off
  function automatic logic [17:0] pwc_ratio(input logic [3:0] ps,
                                            input logic lks0);
    logic [17:0] r;
    r = PWC_DIV_RST;
    if (!lks0) begin
      unique case (ps)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'hA: r = 18'h00004;
        4'hB: r = 18'h0000A;
        4'hC: r = 18'h00010;
        4'hD: r = 18'h00064;
        4'hE: r = 18'h001F4;
        4'hF: r = 18'h003E8;
      endcase
    end else begin
      unique case (ps)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003E8;
        4'h9: r = 18'h007D0;
        4'hA: r = 18'h01388;
        4'hB: r = 18'h02710;
        4'hC: r = 18'h04E20;
        4'hD: r = 18'h0C350;
        4'hE: r = 18'h186A0;
        4'hF: r = 18'h30D40;
      endcase
    end
    return r;
  endfunction

endpackage

// ### core/pwc_sync_edge.sv
// Two-flop synchroniser with rising edge pulse for one source clock
module pwc_sync_edge (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic rise_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_o <= sync_r & ~last_r;
    end
  end
endmodule

// ### core/pwc_prescaler.sv
// Prescaler: counts source edges and pulses once per divide period
module pwc_prescaler #(
  parameter int DIV_W = pwc_pkg::PWC_DIV_W
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic src_edge_i,
  input wire logic [pwc_pkg::PWC_PS_W-1:0] ps_i,
  input wire logic lks0_i,
  input wire logic clr_i,
  output logic tick_o
);
  import pwc_pkg::*;

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] last_val;

  assign last_val = DIV_W'(pwc_ratio(ps_i, lks0_i)) - DIV_W'(1);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= DIV_W'(PWC_DIV_RST);
      tick_o <= 1'b0;
    end else if (clr_i || ps_i == PWC_PS_OFF) begin
      div_r <= DIV_W'(PWC_DIV_RST);
      tick_o <= 1'b0;
    end else if (src_edge_i) begin
      if (div_r == last_val) begin
        div_r <= DIV_W'(PWC_DIV_RST);
        tick_o <= 1'b1;
      end else begin
        div_r <= div_r + DIV_W'(1);
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule

// ### core/pwc_top.sv
// Periodic wakeup counter: source select, prescaler, modulo counter, flag
//
// Contract
// (R1) 8-bit up-counter to modulo value, clocked by selectable prescaler.
// (R2) Reset: counter stopped at 0x00, modulo 0x00, prescaler off.
// (R3) Reset selects the 1 kHz low-power oscillator as source.
// (R4) Prescaler off while prescale select is zero; runs once nonzero.
// (R5) Select 00 low-power, 01 external, 1x internal reference clock.
// (R6) Writing a different clock select clears prescaler and counter.
// (R7) Prescale select with clock select bit 0 picks divide ratio.
// (R8) Writing a different prescale select clears prescaler and counter.
// (R9) Prescaler periods follow the period table, e.g. 8 ms and 1 s.
// (R10) Any modulo value 0x00 through 0xFF is accepted.
// (R11) Counter increments per event until equal modulo, then wraps to 0x00.
// (R12) Flag sets when counter moves from modulo value to 0x00.
// (R13) Any modulo write clears prescaler and counter.
// (R14) Interrupt request is flag AND interrupt enable.
// (R15) Writing 1 to the flag clears flag and pending request.
// (R16) Status bits: flag 7, clock select 6-5, enable 4, prescale 3-0.
// (R17) Writing 0 to the flag bit leaves it unchanged.
// (R18) Count is read-only and shows the current counter value.
// (R19) Modulo 0x00 sets the flag on every prescaler event.
// (R20) Source clocks cross safely into the reference clock domain.
module pwc_top (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic low_power_oscillator_clock_i,
  input wire logic external_reference_clock_i,
  input wire logic internal_reference_clock_i,
  input wire logic ctrl_wr_i,
  input wire logic [pwc_pkg::PWC_DATA_W-1:0] ctrl_wdata_i,
  input wire logic modulo_wr_i,
  input wire logic [pwc_pkg::PWC_DATA_W-1:0] modulo_wdata_i,
  output logic [pwc_pkg::PWC_DATA_W-1:0] counter_control_status_o,
  output logic [pwc_pkg::PWC_DATA_W-1:0] current_count_o,
  output logic [pwc_pkg::PWC_DATA_W-1:0] modulo_compare_value_o,
  output logic match_interrupt_o
);
  import pwc_pkg::*;

  logic match_interrupt_flag_r;
  logic match_interrupt_flag_nxt;
  logic match_interrupt_enable_r;
  logic [PWC_CLKS_W-1:0] counter_clock_select_r;
  logic [PWC_PS_W-1:0] prescale_select_r;
  logic [PWC_DATA_W-1:0] count_r;
  logic [PWC_DATA_W-1:0] modulo_r;
  logic irq_r;
  logic irq_nxt;

  logic lpo_rise;
  logic ext_rise;
  logic int_rise;
  logic src_edge;
  logic pre_tick;
  logic clr_req;
  logic wrap_evt;
  logic flag_clr;

  logic [PWC_CLKS_W-1:0] wr_clks;
  logic [PWC_PS_W-1:0] wr_ps;

  assign wr_clks = ctrl_wdata_i[PWC_CLKS_MSB:PWC_CLKS_LSB];
  assign wr_ps = ctrl_wdata_i[PWC_PS_MSB:PWC_PS_LSB];

  // Each source is sampled through two flops before edge detection
  pwc_sync_edge u_sync_lpo ( // (R20)
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(low_power_oscillator_clock_i),
    .rise_o(lpo_rise)
  );

  pwc_sync_edge u_sync_ext ( // (R20)
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(external_reference_clock_i),
    .rise_o(ext_rise)
  );

  pwc_sync_edge u_sync_int ( // (R20)
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(internal_reference_clock_i),
    .rise_o(int_rise)
  );

  // Source multiplexer
  always_comb begin
    unique case (counter_clock_select_r)
      PWC_SRC_LPO: src_edge = lpo_rise; // (R5)
      PWC_SRC_EXT: src_edge = ext_rise; // (R5)
      default: src_edge = int_rise; // (R5)
    endcase
  end

  // Clears of prescaler and counter
  always_comb begin
    clr_req = 1'b0;
    if (ctrl_wr_i && wr_clks != counter_clock_select_r) begin
      clr_req = 1'b1; // (R6)
    end
    if (ctrl_wr_i && wr_ps != prescale_select_r) begin
      clr_req = 1'b1; // (R8)
    end
    if (modulo_wr_i) begin
      clr_req = 1'b1; // (R13)
    end
  end

  pwc_prescaler #(
    .DIV_W(PWC_DIV_W)
  ) u_prescaler ( // (R7) (R9)
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .src_edge_i(src_edge),
    .ps_i(prescale_select_r),
    .lks0_i(counter_clock_select_r[0]),
    .clr_i(clr_req),
    .tick_o(pre_tick)
  );

  assign wrap_evt = pre_tick && !clr_req && count_r == modulo_r; // (R12)
  assign flag_clr = ctrl_wr_i && ctrl_wdata_i[PWC_FLAG_BIT]; // (R15) (R17)

  // Set beats a simultaneous write-one clear
  assign match_interrupt_flag_nxt = wrap_evt ||
                                    (match_interrupt_flag_r && !flag_clr);
  assign irq_nxt = match_interrupt_flag_nxt &&
                   (ctrl_wr_i ? ctrl_wdata_i[PWC_IE_BIT]
                              : match_interrupt_enable_r); // (R14)

  // Control fields
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      counter_clock_select_r <= PWC_CLKS_RST; // (R3)
      prescale_select_r <= PWC_PS_OFF; // (R2)
      match_interrupt_enable_r <= 1'b0;
    end else if (ctrl_wr_i) begin
      counter_clock_select_r <= wr_clks;
      prescale_select_r <= wr_ps; // (R4)
      match_interrupt_enable_r <= ctrl_wdata_i[PWC_IE_BIT];
    end
  end

  // Modulo value
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      modulo_r <= PWC_MOD_RST; // (R2)
    end else if (modulo_wr_i) begin
      modulo_r <= modulo_wdata_i; // (R10)
    end
  end

  // Modulo counter
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_r <= PWC_COUNT_RST; // (R2)
    end else if (clr_req) begin
      count_r <= PWC_COUNT_RST;
    end else if (pre_tick) begin
      if (count_r == modulo_r) begin
        count_r <= PWC_COUNT_RST; // (R11)
      end else begin
        count_r <= count_r + 8'h01; // (R1) (R11)
      end
    end
  end

  // Flag and request
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_interrupt_flag_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      match_interrupt_flag_r <= match_interrupt_flag_nxt; // (R12) (R19)
      irq_r <= irq_nxt; // (R14) (R15)
    end
  end

  // Readback and request outputs
  assign counter_control_status_o = {match_interrupt_flag_r,
                                     counter_clock_select_r,
                                     match_interrupt_enable_r,
                                     prescale_select_r}; // (R16)
  assign current_count_o = count_r; // (R18)
  assign modulo_compare_value_o = modulo_r;
  assign match_interrupt_o = irq_r;

  property p_reset_state;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> count_r == PWC_COUNT_RST &&
      modulo_r == PWC_MOD_RST && prescale_select_r == PWC_PS_OFF &&
      counter_clock_select_r == PWC_SRC_LPO;
  endproperty
  a_reset_state: assert property (p_reset_state) // (R2) (R3)
    else $error("state not cleared after reset");

  property p_off_no_tick;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    prescale_select_r == PWC_PS_OFF && $stable(prescale_select_r)
      |-> !pre_tick && $stable(count_r);
  endproperty
  a_off_no_tick: assert property (p_off_no_tick) // (R4)
    else $error("prescaler ran while off");

  property p_clks_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_wr_i && wr_clks != counter_clock_select_r
      |=> count_r == PWC_COUNT_RST && !pre_tick;
  endproperty
  a_clks_clear: assert property (p_clks_clear) // (R6)
    else $error("clock select change did not clear counter");

  property p_ps_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_wr_i && wr_ps != prescale_select_r
      |=> count_r == PWC_COUNT_RST && !pre_tick;
  endproperty
  a_ps_clear: assert property (p_ps_clear) // (R8)
    else $error("prescale change did not clear counter");

  property p_mod_write;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    modulo_wr_i |=> count_r == PWC_COUNT_RST &&
      modulo_r == $past(modulo_wdata_i);
  endproperty
  a_mod_write: assert property (p_mod_write) // (R13) (R10)
    else $error("modulo write did not load value and clear count");

  property p_increment;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pre_tick && !clr_req && count_r != modulo_r
      |=> count_r == $past(count_r) + 8'h01 &&
          current_count_o == count_r;
  endproperty
  a_increment: assert property (p_increment) // (R11) (R18)
    else $error("counter did not increment on event");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pre_tick && !clr_req && count_r == modulo_r
      |=> count_r == PWC_COUNT_RST && match_interrupt_flag_r;
  endproperty
  a_wrap: assert property (p_wrap) // (R12)
    else $error("wrap did not clear count and set flag");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !pre_tick && !clr_req |=> $stable(count_r);
  endproperty
  a_hold: assert property (p_hold) // (R1)
    else $error("counter moved without prescaler event");

  property p_mod_zero;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pre_tick && !clr_req && modulo_r == PWC_MOD_RST
      |=> match_interrupt_flag_r && count_r == PWC_COUNT_RST;
  endproperty
  a_mod_zero: assert property (p_mod_zero) // (R19)
    else $error("zero modulo did not flag every event");

  property p_irq;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ##1 match_interrupt_o ==
      (match_interrupt_flag_r && match_interrupt_enable_r);
  endproperty
  a_irq: assert property (p_irq) // (R14)
    else $error("request differs from flag and enable");

  property p_flag_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    flag_clr && !wrap_evt |=> !match_interrupt_flag_r &&
      !match_interrupt_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // (R15)
    else $error("write one did not clear flag and request");

  property p_flag_keep;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    match_interrupt_flag_r && ctrl_wr_i && !ctrl_wdata_i[PWC_FLAG_BIT]
      |=> match_interrupt_flag_r;
  endproperty
  a_flag_keep: assert property (p_flag_keep) // (R17)
    else $error("write zero changed the flag");

  property p_status_layout;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_wr_i |=> counter_control_status_o[6:0] == $past(ctrl_wdata_i[6:0]);
  endproperty
  a_status_layout: assert property (p_status_layout) // (R16)
    else $error("status fields misplaced");

  property p_source_edge;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    counter_clock_select_r == PWC_SRC_EXT |-> src_edge == ext_rise;
  endproperty
  a_source_edge: assert property (p_source_edge) // (R5)
    else $error("wrong source edge selected");

endmodule

// ### dv/tb_pwc_top.sv
// Self-checking testbench for the periodic wakeup counter
module tb_pwc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwc_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] src = 3'h0;
  logic ctrl_wr_i = 1'b0;
  logic modulo_wr_i = 1'b0;
  logic [7:0] ctrl_wdata_i = 8'h00;
  logic [7:0] modulo_wdata_i = 8'h00;
  logic [7:0] sts_o, cnt_o, mod_o;
  logic irq_o;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] q_cnt[$];
  logic [8:0] q_sts[$];
  logic [7:0] p_cnt = 8'h00;
  logic [8:0] p_sts = 9'h000;
  // Reference model of the counter
  logic [7:0] m_cnt = 8'h00;
  logic [7:0] m_mod = 8'h00;
  logic [8:0] m_sts = 9'h000;
  logic m_flag = 1'b0;
  logic m_ie = 1'b0;
  logic [1:0] m_clks = 2'h0;
  logic [3:0] m_ps = 4'h0;
  int m_div = 0;
  int m_ratio = 0;
  logic [8:0] m_exp = 9'h000;
  int rt0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100,
                  500, 1000};
  int rt1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000,
                  2000, 5000, 10000, 20000, 50000, 100000, 200000};
  logic [1:0] tc[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
  logic [3:0] tp[7] = '{4'h8, 4'h1, 4'h9, 4'hB, 4'hA, 4'h8, 4'h8};

  always #10 ref_clk_i = ~ref_clk_i;

  pwc_top dut_u (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .low_power_oscillator_clock_i(src[0]),
    .external_reference_clock_i(src[1]),
    .internal_reference_clock_i(src[2]),
    .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i),
    .modulo_wr_i(modulo_wr_i),
    .modulo_wdata_i(modulo_wdata_i),
    .counter_control_status_o(sts_o),
    .current_count_o(cnt_o),
    .modulo_compare_value_o(mod_o),
    .match_interrupt_o(irq_o)
  );

  task automatic cmp9(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Monitor: every count or status change consumes the oldest note of its kind
  always @(posedge ref_clk_i) begin
    #1;
    if (rstn_i) begin
      if (cnt_o !== p_cnt) begin
        m_exp = {1'b0, p_cnt};
        if (q_cnt.size() != 0) begin
          m_exp = {1'b0, q_cnt.pop_front()};
        end
        cmp9("count", m_exp, {1'b0, cnt_o});
      end
      if ({sts_o, irq_o} !== p_sts) begin
        m_exp = p_sts;
        if (q_sts.size() != 0) begin
          m_exp = q_sts.pop_front();
        end
        cmp9("status", m_exp, {sts_o, irq_o});
      end
    end
    p_cnt = cnt_o;
    p_sts = {sts_o, irq_o};
  end

  task automatic push_sts;
    logic [8:0] s;
    s = {m_flag, m_clks, m_ie, m_ps, m_flag & m_ie};
    if (s !== m_sts) begin
      q_sts.push_back(s);
    end
    m_sts = s;
  endtask

  task automatic set_cnt(input logic [7:0] v);
    if (v !== m_cnt) begin
      q_cnt.push_back(v);
    end
    m_cnt = v;
  endtask

  task automatic drain;
    int i;
    i = 0;
    while ((q_cnt.size() != 0 || q_sts.size() != 0) && i < 40) begin
      @(posedge ref_clk_i);
      i++;
    end
    if (i == 40) begin
      err_total++;
      $display("unexpected wait: expected 0 notes left seen %0d",
               q_cnt.size() + q_sts.size());
      print_verdict();
    end
  endtask

  task automatic wr_ctrl(input logic [7:0] d);
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b1;
    ctrl_wdata_i <= d;
    if (d[6:5] != m_clks || d[3:0] != m_ps) begin
      m_div = 0;
      set_cnt(8'h00);
    end
    if (d[7]) begin
      m_flag = 1'b0;
    end
    m_clks = d[6:5];
    m_ie = d[4];
    m_ps = d[3:0];
    m_ratio = m_clks[0] ? rt1[m_ps] : rt0[m_ps];
    push_sts();
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b0;
  endtask

  task automatic wr_mod(input logic [7:0] d);
    @(posedge ref_clk_i);
    modulo_wr_i <= 1'b1;
    modulo_wdata_i <= d;
    m_mod = d;
    m_div = 0;
    set_cnt(8'h00);
    @(posedge ref_clk_i);
    modulo_wr_i <= 1'b0;
    #1;
    cmp9("modulo", {1'b0, d}, {1'b0, mod_o});
  endtask

  // Slow source pulses; counted ones advance the model divider
  task automatic pulses(input int k, input int n, input bit counted);
    int h;
    repeat (n) begin
      h = $urandom_range(4, 2);
      @(posedge ref_clk_i);
      src[k] <= 1'b1;
      // Note goes in before the synchronised edge can move the count
      if (counted && m_ratio != 0) begin
        m_div++;
        if (m_div == m_ratio) begin
          m_div = 0;
          m_flag = m_flag | (m_cnt == m_mod);
          set_cnt(m_cnt == m_mod ? 8'h00 : m_cnt + 8'h01);
          push_sts();
        end
      end
      repeat (h) @(posedge ref_clk_i);
      src[k] <= 1'b0;
      repeat (h - 1) @(posedge ref_clk_i);
    end
    repeat (8) @(posedge ref_clk_i);
    drain();
  endtask

  task automatic endt(input string nm);
    drain();
    $display("test %s done, mismatches so far %0d", nm, err_total);
  endtask

  initial begin
    int k;
    int m;
    void'($urandom(63791));
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    cmp9("status", 9'h000, {sts_o, irq_o});
    cmp9("count", 9'h000, {1'b0, cnt_o});
    cmp9("modulo", 9'h000, {1'b0, mod_o});
    endt("reset");
    pulses(0, 6, 1);
    cmp9("count", 9'h000, {1'b0, cnt_o});
    endt("prescaler off");
    for (int i = 0; i < 7; i++) begin
      wr_ctrl({1'b1, tc[i], 1'b1, tp[i]});
      wr_mod(8'h02);
      k = tc[i][1] ? 2 : int'(tc[i][0]);
      pulses((k + 1) % 3, 3, 1'b0);
      m = m_ratio >= 1000 ? 2 * m_ratio : 4 * m_ratio;
      pulses(k, m, 1'b1);
      endt("divide table entry");
    end
    // Remaining low-power codes, one prescaler event each
    for (int c = 2; c < 16; c++) begin
      if (c < 8 || c > 11) begin
        wr_ctrl({4'h8, 4'(c)});
        pulses(0, m_ratio, 1'b1);
      end
    end
    endt("remaining ratios");
    wr_ctrl(8'h98);
    m = $urandom_range(5, 1);
    wr_mod(8'(m));
    pulses(0, m + 2, 1'b1);
    wr_ctrl(8'h18);
    wr_ctrl(8'h08);
    wr_ctrl(8'h98);
    pulses(0, 1, 1'b1);
    wr_mod(8'(m));
    endt("same-value writes");
    wr_mod(8'h00);
    pulses(0, 1, 1'b1);
    wr_ctrl(8'h98);
    pulses(0, 1, 1'b1);
    endt("modulo zero");
    repeat (4) wr_mod(8'($urandom_range(255, 0)));
    endt("modulo range");
    // Second reset in mid-run, with flag and request set
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    cmp9("status", 9'h000, {sts_o, irq_o});
    cmp9("count", 9'h000, {1'b0, cnt_o});
    cmp9("modulo", 9'h000, {1'b0, mod_o});
    endt("mid-run reset");
    print_verdict();
  end
endmodule
